// File: fpa_cfg.svh
// fpa_cfg.svh: sizes, format limits and timing counts of the readout sequencer
// assumes: mclk is the pixel timebase, one mclk period per pixel clock period
`ifndef FPA_CFG_SVH
`define FPA_CFG_SVH

// ****************************************************************
// widths and depths
// ****************************************************************
`define ROW_W 10
`define QUAD_W 8
`define PIX_W 14
`define LANES 4
`define FIFO_DEPTH 16
`define TMR_W 12

// ****************************************************************
// fixed formats: rows and four-pixel columns per row
// ****************************************************************
`define ROWS_FULL 10'h200
`define ROWS_SHORT 10'h1E0
`define QUADS_FULL 8'hA0
`define QUADS_SQUARE 8'h80

// ****************************************************************
// times in half timebase periods, counts rounded up to whole cycles
// ****************************************************************
`define CAP_RESET_HALF_MC 6151
`define ITR_LAT_HALF_MC 5
`define IWR_LAT_HALF_MC 6231
`define HALF_TO_CYC(h) (((h) + 1) / 2)
`define CAP_RESET_CYC `TMR_W'(`HALF_TO_CYC(`CAP_RESET_HALF_MC))
`define ITR_LAT_CYC `TMR_W'(`HALF_TO_CYC(`ITR_LAT_HALF_MC))
`define IWR_LAT_CYC `TMR_W'(`HALF_TO_CYC(`IWR_LAT_HALF_MC))

`endif

// File: fpa_pkg.sv
// fpa_pkg.sv: state codes and carrier structs of the readout sequencer
// assumes: fpa_cfg.svh is on the include path
`include "fpa_cfg.svh"

package fpa_pkg;

	// ****************************************************************
	// state machines
	// ****************************************************************
	typedef enum logic [1:0] {
		INT_IDLE   = 2'b00,
		INT_RESET  = 2'b01,
		INT_ACTIVE = 2'b10
	} integ_state_e;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b00,
		RD_WAIT = 2'b01,
		RD_RUN  = 2'b10
	} read_state_e;

	// ****************************************************************
	// one readout beat: four pixels of a row in parallel
	// ****************************************************************
	typedef struct packed {
		logic [`ROW_W-1:0]         row;
		logic [`QUAD_W-1:0]        quad;
		logic                      last;
		logic [`LANES*`PIX_W-1:0]  pix;
	} pixel_beat_s;

	// ****************************************************************
	// whole state of the sequencer
	// ****************************************************************
	typedef struct packed {
		logic [1:0]                gate_sync;
		logic                      gate_prev;
		logic [1:0]                mode_sync;
		logic [1:0]                sza_sync;
		logic [1:0]                szb_sync;
		logic [1:0][`ROW_W-1:0]    wrow_sync;
		logic [1:0][`QUAD_W-1:0]   wquad_sync;
		integ_state_e              istate;
		logic [`TMR_W-1:0]         itmr;
		logic                      cap_reset;
		logic                      integrating;
		read_state_e               rstate;
		logic [`TMR_W-1:0]         rtmr;
		logic                      pending;
		logic [`ROW_W-1:0]         rows_lim;
		logic [`QUAD_W-1:0]        quads_lim;
		logic                      row_output_valid;
		logic                      out_valid;
		pixel_beat_s               out_beat;
	} sequencer_state_s;

endpackage

// File: wrap_counter.sv
// wrap_counter.sv: synchronous address counter that wraps at a run-time limit
// assumes: limit is held stable while the counter runs, and is at least one
`timescale 1ns/1ps
`default_nettype none

module wrap_counter #(
	parameter int W = 8
) (
	input  wire logic         mclk,
	input  wire logic         srst,
	input  wire logic         clr,
	input  wire logic         en,
	input  wire logic [W-1:0] limit,
	output logic      [W-1:0] count,
	output logic              at_last
);

	typedef struct packed {
		logic [W-1:0] count;
	} cnt_state_s;

	cnt_state_s st_reg;
	cnt_state_s st_next;

	// step by one, back to zero after the last position
	always_comb begin
		st_next = st_reg;
		if (clr) begin
			st_next.count = '0;
		end else if (en) begin
			st_next.count = at_last ? '0 : W'(st_reg.count + 1'b1);
		end
	end

	// register the state
	always_ff @(posedge mclk) begin
		if (srst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign count   = st_reg.count;
	assign at_last = (st_reg.count == W'(limit - 1'b1));

endmodule

`default_nettype wire

// File: beat_fifo.sv
// beat_fifo.sv: flip-flop FIFO with valid and ready on both sides
// assumes: DEPTH is a power of two
`timescale 1ns/1ps
`default_nettype none

module beat_fifo #(
	parameter int W     = 75,
	parameter int DEPTH = 16
) (
	input  wire logic         mclk,
	input  wire logic         srst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} fifo_state_s;

	fifo_state_s st_reg;
	fifo_state_s st_next;
	logic        push;
	logic        pop;

	// full and empty come straight from the fill count
	assign in_ready  = (st_reg.cnt != (AW+1)'(DEPTH));
	assign out_valid = (st_reg.cnt != '0);
	assign out_data  = st_reg.mem[st_reg.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// write at the tail, read at the head
	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.mem[st_reg.wp] = in_data;
			st_next.wp             = AW'(st_reg.wp + 1'b1);
		end
		if (pop) begin
			st_next.rp = AW'(st_reg.rp + 1'b1);
		end
		if (push && !pop) begin
			st_next.cnt = (AW+1)'(st_reg.cnt + 1'b1);
		end else if (pop && !push) begin
			st_next.cnt = (AW+1)'(st_reg.cnt - 1'b1);
		end
	end

	// register the state
	always_ff @(posedge mclk) begin
		if (srst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

endmodule

`default_nettype wire

// File: fpa_readout_timing_sequencer.sv
// fpa_readout_timing_sequencer.sv: snapshot integration and four-lane readout sequencer
// assumes: mclk is the pixel timebase; exposure gate, mode and format pins are asynchronous;
// lane_sample is the four multiplexer outputs for the current address, on the same clock
`timescale 1ns/1ps
`default_nettype none

module fpa_readout_timing_sequencer
	import fpa_pkg::*;
(
	input  wire logic                       mclk,
	input  wire logic                       srst,
	input  wire logic                       int_gate,
	input  wire logic                       integrate_then_read_mode,
	input  wire logic                       size_a,
	input  wire logic                       size_b,
	input  wire logic [`ROW_W-1:0]          win_rows,
	input  wire logic [`QUAD_W-1:0]         win_quads,
	input  wire logic [`LANES*`PIX_W-1:0]   lane_sample,
	input  wire logic                       out_ready,
	output logic                            cap_reset,
	output logic                            integrating,
	output logic [`ROW_W-1:0]               addr_row,
	output logic [`QUAD_W-1:0]              addr_quad,
	output logic                            row_output_valid,
	output logic                            out_valid,
	output pixel_beat_s                     out_beat
);

	localparam int BEAT_W = $bits(pixel_beat_s);

	sequencer_state_s st_reg;
	sequencer_state_s st_next;
	logic             gate_rise;
	logic             gate_fall;
	logic             quad_last;
	logic             row_last;
	logic             push_valid;
	logic             push_ready;
	logic             push_ok;
	logic             run_start;
	logic             fifo_valid;
	logic             take;
	pixel_beat_s      push_beat;
	pixel_beat_s      fifo_beat;

	// ****************************************************************
	// address counters and output buffer
	// ****************************************************************

	// edges of the synchronised gate
	assign gate_rise  = st_reg.gate_sync[1] && !st_reg.gate_prev;
	assign gate_fall  = !st_reg.gate_sync[1] && st_reg.gate_prev;
	assign run_start  = (st_reg.rstate == RD_WAIT) && (st_reg.rtmr == '0);
	assign push_valid = (st_reg.rstate == RD_RUN);
	assign push_ok    = push_valid && push_ready;
	assign take       = fifo_valid && (!st_reg.out_valid || out_ready);

	// one beat per clock carries all four lanes of the current address
	always_comb begin
		push_beat      = '0;
		push_beat.row  = addr_row;
		push_beat.quad = addr_quad;
		push_beat.last = quad_last && row_last;
		push_beat.pix  = lane_sample;
	end

	// column position steps every accepted beat
	wrap_counter #(
		.W(`QUAD_W)
	) u_quad_cnt (
		.mclk    (mclk),
		.srst    (srst),
		.clr     (run_start),
		.en      (push_ok),
		.limit   (st_reg.quads_lim),
		.count   (addr_quad),
		.at_last (quad_last)
	);

	// row position steps when a row is done
	wrap_counter #(
		.W(`ROW_W)
	) u_row_cnt (
		.mclk    (mclk),
		.srst    (srst),
		.clr     (run_start),
		.en      (push_ok && quad_last),
		.limit   (st_reg.rows_lim),
		.count   (addr_row),
		.at_last (row_last)
	);

	// buffer absorbs stalls of the receiver; a full buffer halts the counters
	beat_fifo #(
		.W     (BEAT_W),
		.DEPTH (`FIFO_DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.srst      (srst),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   (push_beat),
		.out_valid (fifo_valid),
		.out_ready (take),
		.out_data  (fifo_beat)
	);

	// ****************************************************************
	// sequencer next state
	// ****************************************************************
	always_comb begin
		st_next = st_reg;
		// two flip-flops on every asynchronous pin input
		st_next.gate_sync  = {st_reg.gate_sync[0], int_gate};
		st_next.gate_prev  = st_reg.gate_sync[1];
		st_next.mode_sync  = {st_reg.mode_sync[0], integrate_then_read_mode};
		st_next.sza_sync   = {st_reg.sza_sync[0], size_a};
		st_next.szb_sync   = {st_reg.szb_sync[0], size_b};
		st_next.wrow_sync  = {st_reg.wrow_sync[0], win_rows};
		st_next.wquad_sync = {st_reg.wquad_sync[0], win_quads};

		// integration: reset phase, then accumulation until the gate falls
		unique case (st_reg.istate)
			INT_IDLE: begin
				if (gate_rise) begin
					st_next.istate    = INT_RESET;
					st_next.itmr      = `TMR_W'(`CAP_RESET_CYC - 1'b1);
					st_next.cap_reset = 1'b1;
				end
			end
			INT_RESET: begin
				if (gate_fall) begin
					st_next.istate    = INT_IDLE;
					st_next.cap_reset = 1'b0;
				end else if (st_reg.itmr == '0) begin
					st_next.istate      = INT_ACTIVE;
					st_next.cap_reset   = 1'b0;
					st_next.integrating = 1'b1;
				end else begin
					st_next.itmr = `TMR_W'(st_reg.itmr - 1'b1);
				end
			end
			INT_ACTIVE: begin
				if (gate_fall) begin
					st_next.istate      = INT_IDLE;
					st_next.integrating = 1'b0;
				end
			end
			default: begin
				st_next.istate      = INT_IDLE;
				st_next.cap_reset   = 1'b0;
				st_next.integrating = 1'b0;
			end
		endcase

		// overlapped mode reads the previous frame during the next one
		if (gate_fall && !st_reg.mode_sync[1]) begin
			st_next.pending = 1'b1;
		end

		// readout: latency wait, then one beat per clock over the window
		unique case (st_reg.rstate)
			RD_IDLE: begin
				if ((gate_fall && st_reg.mode_sync[1]) ||
					(gate_rise && !st_reg.mode_sync[1] && st_reg.pending)) begin
					st_next.rstate = RD_WAIT;
					st_next.rtmr   = st_reg.mode_sync[1] ?
						`TMR_W'(`ITR_LAT_CYC - 1'b1) :
						`TMR_W'(`IWR_LAT_CYC - 1'b1);
					if (gate_rise) begin
						st_next.pending = 1'b0;
					end
					// format is frozen for the whole readout
					unique case ({st_reg.sza_sync[1], st_reg.szb_sync[1]})
						2'b11: begin
							st_next.rows_lim  = `ROWS_FULL;
							st_next.quads_lim = `QUADS_FULL;
						end
						2'b10: begin
							st_next.rows_lim  = `ROWS_SHORT;
							st_next.quads_lim = `QUADS_FULL;
						end
						2'b01: begin
							st_next.rows_lim  = `ROWS_FULL;
							st_next.quads_lim = `QUADS_SQUARE;
						end
						2'b00: begin
							st_next.rows_lim  = st_reg.wrow_sync[1];
							st_next.quads_lim = st_reg.wquad_sync[1];
						end
					endcase
				end
			end
			RD_WAIT: begin
				if (run_start) begin
					st_next.rstate           = RD_RUN;
					st_next.row_output_valid = 1'b1;
				end else begin
					st_next.rtmr = `TMR_W'(st_reg.rtmr - 1'b1);
				end
			end
			RD_RUN: begin
				if (push_ok && push_beat.last) begin
					st_next.rstate           = RD_IDLE;
					st_next.row_output_valid = 1'b0;
				end
			end
			default: begin
				st_next.rstate           = RD_IDLE;
				st_next.row_output_valid = 1'b0;
			end
		endcase

		// output register: hold until the receiver takes it
		if (take) begin
			st_next.out_valid = 1'b1;
			st_next.out_beat  = fifo_beat;
		end else if (out_ready) begin
			st_next.out_valid = 1'b0;
		end
	end

	// register the state
	always_ff @(posedge mclk) begin
		if (srst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from flip-flops
	assign cap_reset        = st_reg.cap_reset;
	assign integrating      = st_reg.integrating;
	assign row_output_valid = st_reg.row_output_valid;
	assign out_valid        = st_reg.out_valid;
	assign out_beat         = st_reg.out_beat;

	// ****************************************************************
	// assertions
	// ****************************************************************

	// length of the current capacitor reset, for checking
	logic [`TMR_W-1:0] cap_len_reg;
	always_ff @(posedge mclk) begin
		if (srst || !st_reg.cap_reset) begin
			cap_len_reg <= '0;
		end else begin
			cap_len_reg <= `TMR_W'(cap_len_reg + 1'b1);
		end
	end

	property p_int_start;
		@(posedge mclk) disable iff (srst)
		(gate_rise && st_reg.istate == INT_IDLE) |=> st_reg.cap_reset && !st_reg.integrating;
	endproperty
	a_int_start: assert property (p_int_start) else $error("reset did not follow gate rise");

	property p_int_end;
		@(posedge mclk) disable iff (srst)
		gate_fall |=> !st_reg.integrating && !st_reg.cap_reset;
	endproperty
	a_int_end: assert property (p_int_end) else $error("integration ran past gate fall");

	property p_cap_len;
		@(posedge mclk) disable iff (srst)
		($fell(st_reg.cap_reset) && st_reg.integrating) |-> cap_len_reg == `CAP_RESET_CYC;
	endproperty
	a_cap_len: assert property (p_cap_len) else $error("capacitor reset has wrong length");

	property p_quad_step;
		@(posedge mclk) disable iff (srst)
		(push_ok && !quad_last) |=> addr_quad == `QUAD_W'($past(addr_quad) + 1'b1);
	endproperty
	a_quad_step: assert property (p_quad_step) else $error("column did not step by one");

	property p_row_step;
		@(posedge mclk) disable iff (srst)
		(push_ok && quad_last && !row_last) |=> addr_quad == '0 && addr_row == `ROW_W'($past(addr_row) + 1'b1);
	endproperty
	a_row_step: assert property (p_row_step) else $error("row did not step at row end");

	property p_full_fmt;
		@(posedge mclk) disable iff (srst)
		(st_reg.rstate == RD_IDLE && st_next.rstate == RD_WAIT && st_reg.sza_sync[1] && st_reg.szb_sync[1])
		|=> st_reg.rows_lim == `ROWS_FULL && st_reg.quads_lim == `QUADS_FULL;
	endproperty
	a_full_fmt: assert property (p_full_fmt) else $error("full format limits wrong");

	property p_valid_span;
		@(posedge mclk) disable iff (srst)
		$fell(st_reg.row_output_valid) |-> $past(push_ok && push_beat.last);
	endproperty
	a_valid_span: assert property (p_valid_span) else $error("valid fell before window end");

	property p_itr_lat;
		@(posedge mclk) disable iff (srst)
		(gate_fall && st_reg.mode_sync[1] && st_reg.rstate == RD_IDLE) |-> ##4 st_reg.row_output_valid;
	endproperty
	a_itr_lat: assert property (p_itr_lat) else $error("read-after latency wrong");

	property p_iwr_arm;
		@(posedge mclk) disable iff (srst)
		(gate_rise && !st_reg.mode_sync[1] && st_reg.pending && st_reg.rstate == RD_IDLE)
		|=> st_reg.rstate == RD_WAIT && st_reg.rtmr == `TMR_W'(`IWR_LAT_CYC - 1'b1);
	endproperty
	a_iwr_arm: assert property (p_iwr_arm) else $error("overlapped readout not armed");

	property p_out_hold;
		@(posedge mclk) disable iff (srst)
		(st_reg.out_valid && !out_ready) |=> st_reg.out_valid && $stable(st_reg.out_beat);
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("output beat changed while stalled");

	c_itr_frame: cover property (@(posedge mclk) disable iff (srst)
		st_reg.mode_sync[1] && $fell(st_reg.row_output_valid));
	c_iwr_frame: cover property (@(posedge mclk) disable iff (srst)
		!st_reg.mode_sync[1] && st_reg.integrating && st_reg.row_output_valid);
	c_backpress: cover property (@(posedge mclk) disable iff (srst)
		push_valid && !push_ready);

endmodule

`default_nettype wire

// File: camera_ctrl_model.sv
// camera_ctrl_model.sv: camera controller model, drives gate, lane samples and ready
// assumes: the bench makes mclk and calls expose() only while srst is low
`timescale 1ns/1ps
`default_nettype none

module camera_ctrl_model
	import fpa_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  stall_all,
	input  wire logic                  rand_stall,
	input  wire logic [`PIX_W-1:0]     salt,
	input  wire logic [`ROW_W-1:0]     addr_row,
	input  wire logic [`QUAD_W-1:0]    addr_quad,
	input  wire logic                  row_output_valid,
	output var logic                   int_gate,
	output logic [`LANES*`PIX_W-1:0]   lane_sample,
	output logic                       out_ready
);
	logic ready_rnd;

	// array pattern: each lane carries the low four bits of its row, its column and its lane number
	function automatic logic [`LANES*`PIX_W-1:0] pix_of(input logic [`PIX_W-1:0] s,
		input logic [`ROW_W-1:0] r, input logic [`QUAD_W-1:0] qd);
		for (int i = 0; i < `LANES; i++) begin
			pix_of[i*`PIX_W +: `PIX_W] = s ^ {r[3:0], qd, 2'(i)};
		end
	endfunction

	assign lane_sample = pix_of(salt, addr_row, addr_quad);

	// ready moves off the sampling edge, so taken samples are settled
	initial ready_rnd = 1'b1;
	always @(negedge mclk) begin
		ready_rnd <= !rand_stall || 1'($urandom % 2);
	end
	assign out_ready = ready_rnd && !stall_all;

	initial int_gate = 1'b0;

	// gate timed by a cycle count, launched after the valid flag rests two cycles
	task automatic expose(input int len);
		int quiet = 0;
		while (quiet < 2) begin
			@(negedge mclk);
			quiet = row_output_valid ? 0 : quiet + 1;
		end
		int_gate = 1'b1;
		repeat (len) @(negedge mclk);
		int_gate = 1'b0;
	endtask
endmodule

`default_nettype wire

// File: fpa_readout_timing_sequencer_bench.sv
// fpa_readout_timing_sequencer_bench.sv: self-checking bench of the readout sequencer
// assumes: camera_ctrl_model stands at the far side of the pixel and gate pins
`timescale 1ns/1ps
`default_nettype none

`define CHECK(name, exp, got) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
	$display("mismatch %s expected %h seen %h", name, exp, got); end end

module fpa_readout_timing_sequencer_bench
	import fpa_pkg::*;
();
	// ****************************************************************
	// signals
	// ****************************************************************
	logic                        mclk = 1'b0;
	logic                        srst = 1'b1;
	logic                        mode = 1'b1;
	logic                        size_a = 1'b0;
	logic                        size_b = 1'b0;
	logic                        stall_all = 1'b0;
	logic                        rand_stall = 1'b0;
	logic [`ROW_W-1:0]           win_rows = 10'h001;
	logic [`QUAD_W-1:0]          win_quads = 8'h01;
	logic [`PIX_W-1:0]           salt = 14'h0000;
	logic                        int_gate;
	logic [`LANES*`PIX_W-1:0]    lane_sample;
	logic                        out_ready;
	logic                        cap_reset;
	logic                        integrating;
	logic [`ROW_W-1:0]           addr_row;
	logic [`QUAD_W-1:0]          addr_quad;
	logic                        row_output_valid;
	logic                        out_valid;
	pixel_beat_s                 out_beat;
	pixel_beat_s                 e;
	pixel_beat_s                 exp_q[$];
	logic                        prev_cap = 1'b0;
	logic                        prev_int = 1'b0;
	logic                        prev_rov = 1'b0;
	int                          mismatches = 0;
	int                          checks_done = 0;
	int                          cycles = 0;
	int                          cap_cnt = 0;
	int                          int_cnt = 0;
	int                          gap_cnt = 0;
	int                          exp_int = 0;

	initial forever #5 mclk = ~mclk;

	fpa_readout_timing_sequencer dut (.mclk(mclk), .srst(srst), .int_gate(int_gate),
		.integrate_then_read_mode(mode), .size_a(size_a), .size_b(size_b),
		.win_rows(win_rows), .win_quads(win_quads), .lane_sample(lane_sample),
		.out_ready(out_ready), .cap_reset(cap_reset), .integrating(integrating),
		.addr_row(addr_row), .addr_quad(addr_quad), .row_output_valid(row_output_valid),
		.out_valid(out_valid), .out_beat(out_beat));

	camera_ctrl_model ctrl (.mclk(mclk), .stall_all(stall_all), .rand_stall(rand_stall),
		.salt(salt), .addr_row(addr_row), .addr_quad(addr_quad),
		.row_output_valid(row_output_valid), .int_gate(int_gate),
		.lane_sample(lane_sample), .out_ready(out_ready));

	// ****************************************************************
	// monitor: beats against notes, pulse lengths and latencies
	// ****************************************************************
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			final_report();
		end
		if (srst) begin
			cap_cnt = 0;
			int_cnt = 0;
			gap_cnt = 0;
		end else begin
			if (out_valid === 1'b1 && out_ready === 1'b1) begin
				if (exp_q.size() == 0) begin
					mismatches++;
					$display("mismatch out_beat expected none seen %h", out_beat);
				end else begin
					e = exp_q.pop_front();
					`CHECK("out_beat", e, out_beat)
				end
			end
			if (prev_cap && !cap_reset) begin
				`CHECK("cap_reset length", 3076, cap_cnt)
				`CHECK("integrating at reset end", 1'b1, integrating)
			end
			if (prev_int && !integrating)
				`CHECK("integration length", exp_int, int_cnt)
			if (!prev_rov && row_output_valid)
				`CHECK("valid latency", mode ? 2 : 3115, gap_cnt)
			cap_cnt = cap_reset ? cap_cnt + 1 : 0;
			int_cnt = integrating ? int_cnt + 1 : 0;
			gap_cnt = (mode ? (prev_int && !integrating) : (!prev_cap && cap_reset)) ?
				0 : gap_cnt + 1;
		end
		prev_cap = cap_reset;
		prev_int = integrating;
		prev_rov = row_output_valid;
	end

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic frame(input logic md, sa, sb, input int rows, quads, len, n);
		pixel_beat_s b;
		@(negedge mclk);
		mode = md;
		size_a = sa;
		size_b = sb;
		win_rows = `ROW_W'(rows);
		win_quads = `QUAD_W'(quads);
		salt = `PIX_W'($urandom);
		exp_int = len - 3076;
		for (int i = 0; i < n; i++) begin
			b.row = `ROW_W'(i / quads);
			b.quad = `QUAD_W'(i % quads);
			b.last = (i == rows * quads - 1);
			b.pix = ctrl.pix_of(salt, b.row, b.quad);
			exp_q.push_back(b);
		end
		ctrl.expose(len);
	endtask

	task automatic drain;
		wait (exp_q.size() == 0);
		wait (row_output_valid === 1'b0);
		@(negedge mclk);
	endtask

	// reset in mid-run: outputs clear while srst is held
	task automatic do_reset;
		@(negedge mclk);
		stall_all = 1'b1;
		srst = 1'b1;
		repeat (3) @(negedge mclk);
		`CHECK("row_output_valid in reset", 1'b0, row_output_valid)
		`CHECK("out_valid in reset", 1'b0, out_valid)
		`CHECK("cap_reset in reset", 1'b0, cap_reset)
		`CHECK("integrating in reset", 1'b0, integrating)
		exp_q.delete();
		srst = 1'b0;
		stall_all = 1'b0;
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		void'($urandom(32'hB00F0EA5));
		repeat (10) @(posedge mclk);
		@(negedge mclk);
		srst = 1'b0;
		// minimum gate, window readout into a stalled far side until full
		stall_all = 1'b1;
		frame(1'b1, 1'b0, 1'b0, 4, 6, 3077, 24);
		wait (row_output_valid === 1'b1);
		repeat (40) @(negedge mclk);
		stall_all = 1'b0;
		rand_stall = 1'b1;
		drain();
		// smallest window, then a new window on the next frame back to back
		frame(1'b1, 1'b0, 1'b0, 1, 1, 3100, 1);
		drain();
		frame(1'b1, 1'b0, 1'b0, 2, 3, 3078, 6);
		drain();
		// overlapped mode: first frame reads nothing, second reads the first
		do_reset();
		frame(1'b0, 1'b0, 1'b0, 3, 5, 3200, 0);
		frame(1'b0, 1'b0, 1'b0, 3, 5, 3200, 15);
		drain();
		// fixed formats: first row and the wrap into the second, then reset
		for (int f = 0; f < 3; f++) begin
			do_reset();
			frame(1'b1, f != 2, f != 1, f == 1 ? 480 : 512, f == 2 ? 128 : 160, 3080,
				(f == 2 ? 128 : 160) + 2);
			wait (exp_q.size() == 0);
			@(negedge mclk);
			stall_all = 1'b1;
		end
		do_reset();
		final_report();
	end
endmodule

`default_nettype wire
